// >>> bench/dpc_data_path_config_test.sv
// Purpose: Self-checking bench for the data path configuration block
// Assumes: One AXI4-Lite access at a time
// Notes:   Expected values are rebuilt from the field meanings
`timescale 1ns/100ps
`default_nettype none
module dpc_data_path_config_test;
  import dpc_pkg::*;
  // ----------
  // Signals
  // ----------
  logic        clk = 1'b0, nrst = 1'b0, awv = 1'b0, wv = 1'b0, bready = 1'b0;
  logic        arv = 1'b0, rready = 1'b0, rx_act = 1'b0, tx_act = 1'b0, send = 1'b0, dma_v = 1'b0;
  logic [7:0]  awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic [3:0]  wstrb = 4'h0;
  logic [4:0]  rx_lvl = 5'h00, tx_lvl = 5'h00;
  logic [15:0] dma_a = 16'h0, rstart = 16'habcd, dma_d = 16'h5a3c;
  logic        awrdy, wrdy, bvalid, arrdy, rvalid, wmode, swap, laddr, lpbk, auto_en;
  logic        grant, ack, breq, bact, bdone, auto_go, rej, mvalid;
  logic [1:0]  bresp, rresp, resp;
  logic [31:0] rdata, rd, maddr;
  logic [15:0] mdata;
  logic [3:0]  blen;
  logic [4:0]  thr_tab [4] = '{5'h02, 5'h04, 5'h08, 5'h0c};
  logic [3:0]  wrd_tab [4] = '{4'h1, 4'h2, 4'h4, 4'h6};
  int          n_errors = 0, n_compared = 0, n_acks = 0, cycles = 0;

  dpc_data_path_config #(.ADDR_W(8)) uut (
    .REF_CLK(clk), .NRST(nrst), .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awv), .S_AXI_AWREADY(awrdy),
    .S_AXI_WDATA(wdata), .S_AXI_WSTRB(wstrb), .S_AXI_WVALID(wv), .S_AXI_WREADY(wrdy),
    .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready), .S_AXI_ARADDR(araddr),
    .S_AXI_ARVALID(arv), .S_AXI_ARREADY(arrdy), .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp),
    .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready), .WORD_MODE(wmode), .LANE_SWAP(swap),
    .LONG_ADDR(laddr), .LOOPBACK_EN(lpbk), .AUTO_REMOVE_EN(auto_en), .BURST_LEN(blen),
    .RX_ACTIVE(rx_act), .RX_FIFO_BYTES(rx_lvl), .TX_ACTIVE(tx_act), .TX_FIFO_BYTES(tx_lvl),
    .BUS_GRANT(grant), .XFER_ACK(ack), .BUS_REQ(breq), .BURST_ACTIVE(bact), .BURST_DONE(bdone),
    .SEND_CMD(send), .AUTO_REMOVE_START(auto_go), .SEND_REJECT(rej), .DMA_VALID(dma_v),
    .DMA_ADDR(dma_a), .REMOTE_START(rstart), .DMA_DATA_IN(dma_d), .MEM_VALID(mvalid), .MEM_ADDR(maddr),
    .MEM_DATA(mdata));
  dpc_mem_partner mem (.clk(clk), .nrst(nrst), .bus_req(breq), .burst_active(bact), .bus_grant(grant),
    .xfer_ack(ack));

  initial begin
    forever #25 clk = ~clk;
  end
  // Counts accepted transfers and cuts a hang short
  always @(posedge clk) begin
    if (ack && bact) n_acks <= n_acks + 1;
    cycles <= cycles + 1;
    if (cycles == 8000) begin
      n_errors = n_errors + 1;
      summarize();
    end
  end

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    n_compared = n_compared + 1;
    if (got !== exp) begin
      n_errors = n_errors + 1;
      $display("ERROR %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic summarize();
    $display("Compared %0d, errors %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
    logic aw, w;
    aw = 1'b1;
    w = 1'b1;
    resp = 2'h1;
    @(posedge clk);
    awaddr <= a;
    wdata <= d;
    wstrb <= s;
    awv <= 1'b1;
    wv <= 1'b1;
    bready <= 1'b1;
    forever begin
      @(posedge clk);
      if (!aw && !w && bvalid) begin
        resp = bresp;
        break;
      end
      if (aw && awrdy) begin
        aw = 1'b0;
        awv <= 1'b0;
      end
      if (w && wrdy) begin
        w = 1'b0;
        wv <= 1'b0;
      end
    end
    bready <= 1'b0;
  endtask

  task automatic axi_rd(input logic [7:0] a);
    logic ar;
    ar = 1'b1;
    resp = 2'h1;
    rd = 32'h0;
    @(posedge clk);
    araddr <= a;
    arv <= 1'b1;
    rready <= 1'b1;
    forever begin
      @(posedge clk);
      if (!ar && rvalid) begin
        resp = rresp;
        rd = rdata;
        break;
      end
      if (ar && arrdy) begin
        ar = 1'b0;
        arv <= 1'b0;
      end
    end
    rready <= 1'b0;
  endtask

  task automatic cfg(input logic [7:0] v);
    axi_wr(DPC_CFG_ADDR, {24'h0, v}, 4'hf);
    check(resp, DPC_RESP_OKAY);
    repeat (2) @(posedge clk);
  endtask

  task automatic run_burst(input logic rx, input logic [4:0] lvl, input logic want, input logic [3:0] len);
    int a0;
    @(posedge clk);
    rx_act <= rx;
    tx_act <= !rx;
    rx_lvl <= lvl;
    tx_lvl <= lvl;
    a0 = n_acks;
    repeat (3) @(posedge clk);
    check(breq, want);
    while (want) begin
      @(posedge clk);
      if (bact) rx_act <= 1'b0;
      if (bact) tx_act <= 1'b0;
      if (bdone) break;
    end
    if (want) check(n_acks - a0, len);
    rx_act <= 1'b0;
    tx_act <= 1'b0;
  endtask

  initial begin
    logic [7:0]  c, v;
    logic [15:0] a;
    logic [4:0]  thr;
    logic [3:0]  len;
    logic        go, no;
    repeat (4) @(posedge clk);
    nrst <= 1'b1;
    @(posedge clk);
    check(laddr, 1'b1);
    axi_rd(DPC_STATUS_ADDR);
    check(rd[8:0], {1'b0, DPC_CFG_RESET});
    axi_rd(DPC_CFG_ADDR);
    check(resp, DPC_RESP_SLVERR);
    axi_rd(8'h3c);
    check(resp, DPC_RESP_DECERR);
    // Every mode combination, each with one memory transfer, and a send command unless lanes are swapped
    for (c = 8'h00; c < 8'h20; c++) begin
      cfg(c);
      check(wmode, c[0]);
      check(swap, c[0] & c[1]);
      check(laddr, c[2]);
      check(lpbk, !c[3]);
      check(auto_en, c[4]);
      a = 16'h9235 + {8'h00, c};
      dma_a <= a;
      dma_v <= 1'b1;
      @(posedge clk);
      dma_v <= 1'b0;
      @(posedge clk);
      check(mvalid, 1'b1);
      @(posedge clk);
      check(maddr, {c[2] ? rstart : 16'h0, c[0] ? {a[14:0], 1'b0} : a});
      check(mdata, !c[0] ? 16'h003c : (c[1] ? 16'h3c5a : 16'h5a3c));
      // Send only with lanes in the usual order
      if (!(c[0] && c[1])) begin
        send <= 1'b1;
        @(posedge clk);
        send <= 1'b0;
        go = 1'b0;
        no = 1'b0;
        repeat (3) begin
          @(posedge clk);
          go = go | auto_go;
          no = no | rej;
        end
        check({go, no}, {c[4], !c[4]});
      end
    end
    // Every threshold in both widths, receive and transmit
    for (c = 8'h00; c < 8'h08; c++) begin
      v = {1'b1, c[2:1], 4'h6, c[0]};
      thr = thr_tab[c[2:1]];
      len = c[0] ? wrd_tab[c[2:1]] : thr[3:0];
      cfg(v);
      check(blen, len);
      axi_rd(DPC_STATUS_ADDR);
      check(rd[8:0], {2'b10, v[6:0]});
      run_burst(1'b1, thr - 5'h01, 1'b0, len);
      run_burst(1'b1, thr, 1'b1, len);
      run_burst(1'b0, 5'h0e - thr, 1'b0, len);
      run_burst(1'b0, 5'h0d - thr, 1'b1, len);
    end
    axi_wr(DPC_STATUS_ADDR, 32'h0, 4'hf);
    check(resp, DPC_RESP_SLVERR);
    axi_wr(8'h44, 32'h0, 4'hf);
    check(resp, DPC_RESP_DECERR);
    cfg(8'h08);
    axi_wr(DPC_CFG_ADDR, 32'h4, 4'he);
    repeat (2) @(posedge clk);
    check(laddr, 1'b0);
    nrst <= 1'b0;
    repeat (2) @(posedge clk);
    nrst <= 1'b1;
    @(posedge clk);
    check(laddr, 1'b1);
    summarize();
  end
endmodule
`default_nettype wire

// >>> bench/dpc_mem_partner.sv
// Purpose: Memory bus partner that grants held requests and acks transfers
// Assumes: Shares the clock and reset of the block
// Notes:   Grant delay and ack spacing are parameters
`timescale 1ns/100ps
`default_nettype none
module dpc_mem_partner #(
  parameter int GRANT_WAIT = 3,
  parameter int ACK_GAP    = 1
) (
  // Clock and reset
  input  wire logic clk,
  input  wire logic nrst,
  // Memory bus
  input  wire logic bus_req,
  input  wire logic burst_active,
  output logic      bus_grant,
  output logic      xfer_ack
);
  logic [3:0] req_cnt;
  logic [3:0] gap_cnt;
  // ----------
  // Arbiter
  // ----------
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      req_cnt   <= 4'h0;
      gap_cnt   <= 4'h0;
      bus_grant <= 1'b0;
      xfer_ack  <= 1'b0;
    end else begin
      req_cnt   <= (bus_req && !burst_active) ? req_cnt + 4'h1 : 4'h0;
      bus_grant <= bus_req && !burst_active && req_cnt >= GRANT_WAIT;
      gap_cnt   <= (burst_active && gap_cnt < ACK_GAP) ? gap_cnt + 4'h1 : 4'h0;
      // One ack per burst transfer
      xfer_ack  <= burst_active && gap_cnt == ACK_GAP;
    end
  end
endmodule
`default_nettype wire

// >>> rtl/dpc_data_path_config.sv
// Purpose: Data path configuration register and its effects on the DMA memory bus
// Assumes: AXI4-Lite master keeps one read and one write in flight at most
// Notes:   Configuration register is write-only; a status word mirrors live state
`timescale 1ns/100ps
`default_nettype none
module dpc_data_path_config #(
  parameter int ADDR_W = 8
) (
  // Clock and reset
  input  wire logic              REF_CLK,
  input  wire logic              NRST,
  // AXI4-Lite write channels
  input  wire logic [ADDR_W-1:0] S_AXI_AWADDR,
  input  wire logic              S_AXI_AWVALID,
  output logic                   S_AXI_AWREADY,
  input  wire logic [31:0]       S_AXI_WDATA,
  input  wire logic [3:0]        S_AXI_WSTRB,
  input  wire logic              S_AXI_WVALID,
  output logic                   S_AXI_WREADY,
  output logic [1:0]             S_AXI_BRESP,
  output logic                   S_AXI_BVALID,
  input  wire logic              S_AXI_BREADY,
  // AXI4-Lite read channels
  input  wire logic [ADDR_W-1:0] S_AXI_ARADDR,
  input  wire logic              S_AXI_ARVALID,
  output logic                   S_AXI_ARREADY,
  output logic [31:0]            S_AXI_RDATA,
  output logic [1:0]             S_AXI_RRESP,
  output logic                   S_AXI_RVALID,
  input  wire logic              S_AXI_RREADY,
  // Configuration outputs
  output logic                   WORD_MODE,
  output logic                   LANE_SWAP,
  output logic                   LONG_ADDR,
  output logic                   LOOPBACK_EN,
  output logic                   AUTO_REMOVE_EN,
  output logic [3:0]             BURST_LEN,
  // FIFO levels and memory bus arbitration
  input  wire logic              RX_ACTIVE,
  input  wire logic [4:0]        RX_FIFO_BYTES,
  input  wire logic              TX_ACTIVE,
  input  wire logic [4:0]        TX_FIFO_BYTES,
  input  wire logic              BUS_GRANT,
  input  wire logic              XFER_ACK,
  output logic                   BUS_REQ,
  output logic                   BURST_ACTIVE,
  output logic                   BURST_DONE,
  // Send-packet command
  input  wire logic              SEND_CMD,
  output logic                   AUTO_REMOVE_START,
  output logic                   SEND_REJECT,
  // DMA transfer formatting
  input  wire logic              DMA_VALID,
  input  wire logic [15:0]       DMA_ADDR,
  input  wire logic [15:0]       REMOTE_START,
  input  wire logic [15:0]       DMA_DATA_IN,
  output logic                   MEM_VALID,
  output logic [31:0]            MEM_ADDR,
  output logic [15:0]            MEM_DATA
);
  import dpc_pkg::*;

  // ----------------------------------------------------------------
  // Bus slave state
  // ----------------------------------------------------------------
  logic              aw_held_q, aw_held_d;
  logic              w_held_q,  w_held_d;
  logic [ADDR_W-1:0] awaddr_q,  awaddr_d;
  logic [31:0]       wdata_q,   wdata_d;
  logic [3:0]        wstrb_q,   wstrb_d;
  logic              awready_d, wready_d, bvalid_d, arready_d, rvalid_d;
  logic [1:0]        bresp_d,   rresp_d;
  logic [31:0]       rdata_d;
  logic              do_write;
  logic [7:0]        cfg_q,     cfg_d;
  logic              configured_q, configured_d;
  logic [31:0]       status_word;

  // ----------------------------------------------------------------
  // Burst and command state
  // ----------------------------------------------------------------
  dpc_burst_state_t  b_state_q, b_state_d;
  logic [3:0]        burst_left_q, burst_left_d;
  logic              bus_req_d, burst_active_d, burst_done_d;
  logic              auto_start_d, send_reject_d;
  logic [4:0]        thr_bytes;
  logic [5:0]        tx_sum;
  logic              rx_want, tx_want;

  assign do_write    = aw_held_q && w_held_q && !S_AXI_BVALID;
  assign status_word = {18'h00000, burst_left_q, BURST_ACTIVE, configured_q, cfg_q};

  // ----------------------------------------------------------------
  // Register bus
  // ----------------------------------------------------------------
  always_comb begin
    aw_held_d    = aw_held_q;
    w_held_d     = w_held_q;
    awaddr_d     = awaddr_q;
    wdata_d      = wdata_q;
    wstrb_d      = wstrb_q;
    bvalid_d     = S_AXI_BVALID;
    bresp_d      = S_AXI_BRESP;
    rvalid_d     = S_AXI_RVALID;
    rresp_d      = S_AXI_RRESP;
    rdata_d      = S_AXI_RDATA;
    cfg_d        = cfg_q;
    configured_d = configured_q;
    if (S_AXI_AWVALID && S_AXI_AWREADY) begin
      aw_held_d = 1'b1;
      awaddr_d  = S_AXI_AWADDR;
    end
    if (S_AXI_WVALID && S_AXI_WREADY) begin
      w_held_d = 1'b1;
      wdata_d  = S_AXI_WDATA;
      wstrb_d  = S_AXI_WSTRB;
    end
    if (S_AXI_BVALID && S_AXI_BREADY) begin
      bvalid_d = 1'b0;
    end
    if (do_write) begin
      aw_held_d = 1'b0;
      w_held_d  = 1'b0;
      bvalid_d  = 1'b1;
      if (awaddr_q == ADDR_W'(DPC_CFG_ADDR)) begin
        bresp_d = DPC_RESP_OKAY;
        if (wstrb_q[0]) begin
          cfg_d        = wdata_q[7:0] & DPC_CFG_MASK;
          configured_d = 1'b1;
        end
      end else if (awaddr_q == ADDR_W'(DPC_STATUS_ADDR)) begin
        bresp_d = DPC_RESP_SLVERR;
      end else begin
        bresp_d = DPC_RESP_DECERR;
      end
    end
    if (S_AXI_RVALID && S_AXI_RREADY) begin
      rvalid_d = 1'b0;
    end
    if (S_AXI_ARVALID && S_AXI_ARREADY) begin
      rvalid_d = 1'b1;
      rdata_d  = 32'h0000_0000;
      if (S_AXI_ARADDR == ADDR_W'(DPC_CFG_ADDR)) begin
        rresp_d = DPC_RESP_SLVERR;
      end else if (S_AXI_ARADDR == ADDR_W'(DPC_STATUS_ADDR)) begin
        rresp_d = DPC_RESP_OKAY;
        rdata_d = status_word;
      end else begin
        rresp_d = DPC_RESP_DECERR;
      end
    end
    awready_d = !aw_held_d && !bvalid_d;
    wready_d  = !w_held_d && !bvalid_d;
    arready_d = !rvalid_d;
  end

  always_ff @(posedge REF_CLK or negedge NRST) begin
    if (!NRST) begin
      aw_held_q     <= 1'b0;
      w_held_q      <= 1'b0;
      awaddr_q      <= '0;
      wdata_q       <= 32'h0000_0000;
      wstrb_q       <= 4'h0;
      S_AXI_AWREADY <= 1'b0;
      S_AXI_WREADY  <= 1'b0;
      S_AXI_BVALID  <= 1'b0;
      S_AXI_BRESP   <= 2'h0;
      S_AXI_ARREADY <= 1'b0;
      S_AXI_RVALID  <= 1'b0;
      S_AXI_RRESP   <= 2'h0;
      S_AXI_RDATA   <= 32'h0000_0000;
      cfg_q         <= DPC_CFG_RESET;
      configured_q  <= 1'b0;
    end else begin
      aw_held_q     <= aw_held_d;
      w_held_q      <= w_held_d;
      awaddr_q      <= awaddr_d;
      wdata_q       <= wdata_d;
      wstrb_q       <= wstrb_d;
      S_AXI_AWREADY <= awready_d;
      S_AXI_WREADY  <= wready_d;
      S_AXI_BVALID  <= bvalid_d;
      S_AXI_BRESP   <= bresp_d;
      S_AXI_ARREADY <= arready_d;
      S_AXI_RVALID  <= rvalid_d;
      S_AXI_RRESP   <= rresp_d;
      S_AXI_RDATA   <= rdata_d;
      cfg_q         <= cfg_d;
      configured_q  <= configured_d;
    end
  end

  // ----------------------------------------------------------------
  // Mode outputs
  // ----------------------------------------------------------------
  always_ff @(posedge REF_CLK or negedge NRST) begin
    if (!NRST) begin
      WORD_MODE      <= 1'b0;
      LANE_SWAP      <= 1'b0;
      LONG_ADDR      <= 1'b1;
      LOOPBACK_EN    <= 1'b1;
      AUTO_REMOVE_EN <= 1'b0;
      BURST_LEN      <= 4'h2;
    end else begin
      WORD_MODE      <= cfg_q[DPC_WORD_SEL_BIT];
      LANE_SWAP      <= cfg_q[DPC_LANE_ORD_BIT] && cfg_q[DPC_WORD_SEL_BIT];
      LONG_ADDR      <= cfg_q[DPC_LONG_ADDR_BIT];
      LOOPBACK_EN    <= !cfg_q[DPC_LOOP_SEL_BIT];
      AUTO_REMOVE_EN <= cfg_q[DPC_AUTO_INIT_BIT];
      // Burst counts transfers: words in word mode, bytes otherwise
      BURST_LEN      <= cfg_q[DPC_WORD_SEL_BIT] ? thr_bytes[4:1] : thr_bytes[3:0];
    end
  end

  // ----------------------------------------------------------------
  // Thresholds and memory bus bursts
  // ----------------------------------------------------------------
  always_comb begin
    case (cfg_q[DPC_FT_HI_BIT:DPC_FT_LO_BIT])
      2'h0:    thr_bytes = DPC_THR_BYTES_0;
      2'h1:    thr_bytes = DPC_THR_BYTES_1;
      2'h2:    thr_bytes = DPC_THR_BYTES_2;
      default: thr_bytes = DPC_THR_BYTES_3;
    endcase
  end

  assign tx_sum  = {1'b0, TX_FIFO_BYTES} + {1'b0, thr_bytes};
  assign rx_want = RX_ACTIVE && (RX_FIFO_BYTES >= thr_bytes);
  assign tx_want = TX_ACTIVE && (tx_sum <= DPC_TX_THR_OFFSET);

  always_comb begin
    b_state_d      = b_state_q;
    burst_left_d   = burst_left_q;
    bus_req_d      = BUS_REQ;
    burst_active_d = BURST_ACTIVE;
    burst_done_d   = 1'b0;
    case (b_state_q)
      DPC_B_IDLE: begin
        bus_req_d = rx_want || tx_want;
        if (BUS_REQ && BUS_GRANT) begin
          b_state_d      = DPC_B_RUN;
          burst_left_d   = BURST_LEN;
          burst_active_d = 1'b1;
          bus_req_d      = 1'b1;
        end
      end
      default: begin
        if (XFER_ACK) begin
          burst_left_d = burst_left_q - 4'h1;
          if (burst_left_q == 4'h1) begin
            b_state_d      = DPC_B_IDLE;
            burst_active_d = 1'b0;
            burst_done_d   = 1'b1;
            bus_req_d      = 1'b0;
          end
        end
      end
    endcase
  end

  // Send-packet runs only with auto-initialise set
  always_comb begin
    auto_start_d  = SEND_CMD && cfg_q[DPC_AUTO_INIT_BIT];
    send_reject_d = SEND_CMD && !cfg_q[DPC_AUTO_INIT_BIT];
  end

  always_ff @(posedge REF_CLK or negedge NRST) begin
    if (!NRST) begin
      b_state_q         <= DPC_B_IDLE;
      burst_left_q      <= 4'h0;
      BUS_REQ           <= 1'b0;
      BURST_ACTIVE      <= 1'b0;
      BURST_DONE        <= 1'b0;
      AUTO_REMOVE_START <= 1'b0;
      SEND_REJECT       <= 1'b0;
    end else begin
      b_state_q         <= b_state_d;
      burst_left_q      <= burst_left_d;
      BUS_REQ           <= bus_req_d;
      BURST_ACTIVE      <= burst_active_d;
      BURST_DONE        <= burst_done_d;
      AUTO_REMOVE_START <= auto_start_d;
      SEND_REJECT       <= send_reject_d;
    end
  end

  // ----------------------------------------------------------------
  // Address and lane formatting
  // ----------------------------------------------------------------
  dpc_lane_mux u_lane_mux (
    .clk          (REF_CLK),
    .nrst         (NRST),
    .word_mode    (WORD_MODE),
    .lane_swap    (LANE_SWAP),
    .long_addr    (LONG_ADDR),
    .xfer_valid   (DMA_VALID),
    .xfer_addr    (DMA_ADDR),
    .remote_start (REMOTE_START),
    .xfer_data    (DMA_DATA_IN),
    .mem_valid    (MEM_VALID),
    .mem_addr     (MEM_ADDR),
    .mem_data     (MEM_DATA)
  );

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  a_power_up_long: assert property (@(posedge REF_CLK) disable iff (!NRST)
    !configured_q |-> cfg_q[DPC_LONG_ADDR_BIT] && LONG_ADDR)
    else $error("long address select not set before first write");

  a_cfg_write_full: assert property (@(posedge REF_CLK) disable iff (!NRST)
    do_write && awaddr_q == ADDR_W'(DPC_CFG_ADDR) && wstrb_q[0]
    |=> cfg_q == ($past(wdata_q[7:0]) & DPC_CFG_MASK) ##1 WORD_MODE == cfg_q[DPC_WORD_SEL_BIT])
    else $error("configuration write not applied to every field");

  a_cfg_hold: assert property (@(posedge REF_CLK) disable iff (!NRST)
    !do_write |=> $stable(cfg_q))
    else $error("configuration changed without a write");

  a_bit7_ignored: assert property (@(posedge REF_CLK) disable iff (!NRST)
    !cfg_q[7] && !status_word[7])
    else $error("unused bit seven stored");

  a_swap_byte_mode: assert property (@(posedge REF_CLK) disable iff (!NRST)
    !WORD_MODE |-> !LANE_SWAP)
    else $error("lane swap active in byte mode");

  a_loopback_sel: assert property (@(posedge REF_CLK) disable iff (!NRST)
    $fell(cfg_q[DPC_LOOP_SEL_BIT]) |=> LOOPBACK_EN)
    else $error("loopback not entered");

  a_send_gate: assert property (@(posedge REF_CLK) disable iff (!NRST)
    SEND_CMD |=> (AUTO_REMOVE_START == $past(cfg_q[DPC_AUTO_INIT_BIT])) && (SEND_REJECT != AUTO_REMOVE_START))
    else $error("send command gating wrong");

  a_rx_request: assert property (@(posedge REF_CLK) disable iff (!NRST)
    b_state_q == DPC_B_IDLE && RX_ACTIVE && RX_FIFO_BYTES >= thr_bytes |=> BUS_REQ)
    else $error("bus not requested at receive threshold");

  a_tx_threshold: assert property (@(posedge REF_CLK) disable iff (!NRST)
    b_state_q == DPC_B_IDLE && !RX_ACTIVE && TX_ACTIVE && tx_sum > DPC_TX_THR_OFFSET
    && !(BUS_REQ && BUS_GRANT) |=> !BUS_REQ)
    else $error("transmit request below threshold");

  a_burst_length: assert property (@(posedge REF_CLK) disable iff (!NRST)
    $rose(BURST_ACTIVE) |-> burst_left_q == $past(BURST_LEN) && burst_left_q != 4'h0)
    else $error("burst length differs from threshold");

endmodule
`default_nettype wire

// >>> rtl/dpc_lane_mux.sv
// Purpose: Memory bus address and data lane formatting for one DMA transfer
// Assumes: Mode inputs come from registers of the configuration block
// Notes:   Output stage is registered; one cycle from DMA_VALID to mem_valid
`timescale 1ns/100ps
`default_nettype none
module dpc_lane_mux (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        nrst,
  // Modes
  input  wire logic        word_mode,
  input  wire logic        lane_swap,
  input  wire logic        long_addr,
  // Transfer in
  input  wire logic        xfer_valid,
  input  wire logic [15:0] xfer_addr,
  input  wire logic [15:0] remote_start,
  input  wire logic [15:0] xfer_data,
  // Memory bus out
  output logic             mem_valid,
  output logic [31:0]      mem_addr,
  output logic [15:0]      mem_data
);

  logic        valid_d;
  logic [31:0] addr_d;
  logic [15:0] data_d;

  always_comb begin
    valid_d = xfer_valid;
    addr_d  = mem_addr;
    data_d  = mem_data;
    if (xfer_valid) begin
      // Word mode: 32k words, lowest address line held low
      addr_d[15:0]  = word_mode ? {xfer_addr[14:0], 1'b0} : xfer_addr;
      addr_d[31:16] = long_addr ? remote_start : 16'h0000;
      if (!word_mode) begin
        data_d = {8'h00, xfer_data[7:0]};
      end else if (lane_swap) begin
        data_d = {xfer_data[7:0], xfer_data[15:8]};
      end else begin
        data_d = xfer_data;
      end
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      mem_valid <= 1'b0;
      mem_addr  <= 32'h0000_0000;
      mem_data  <= 16'h0000;
    end else begin
      mem_valid <= valid_d;
      mem_addr  <= addr_d;
      mem_data  <= data_d;
    end
  end

  a_word_a0_low: assert property (@(posedge clk) disable iff (!nrst)
    xfer_valid && word_mode |=> mem_valid && !mem_addr[0])
    else $error("word transfer drove address bit zero high");

  a_upper_address: assert property (@(posedge clk) disable iff (!nrst)
    xfer_valid && long_addr |=> mem_addr[31:16] == $past(remote_start))
    else $error("upper address does not carry remote start address");

  a_byte_lanes: assert property (@(posedge clk) disable iff (!nrst)
    xfer_valid && word_mode && lane_swap |=> mem_data == {$past(xfer_data[7:0]), $past(xfer_data[15:8])})
    else $error("byte lanes not swapped in word mode");

endmodule
`default_nettype wire

// >>> rtl/dpc_pkg.sv
// Purpose: Shared constants for the data path configuration block
// Assumes: AXI4-Lite register access with 32-bit data, 8-bit byte addresses
// Notes:   Printed offsets are register indices; byte address is four times the index
package dpc_pkg;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [7:0] DPC_CFG_INDEX     = 8'h0e;
  localparam logic [7:0] DPC_CFG_ADDR      = 8'(DPC_CFG_INDEX * 4);
  localparam logic [7:0] DPC_STATUS_INDEX  = 8'h10;
  localparam logic [7:0] DPC_STATUS_ADDR   = 8'(DPC_STATUS_INDEX * 4);

  // ----------------------------------------------------------------
  // Field positions and reset value
  // ----------------------------------------------------------------
  localparam int         DPC_WORD_SEL_BIT  = 0;
  localparam int         DPC_LANE_ORD_BIT  = 1;
  localparam int         DPC_LONG_ADDR_BIT = 2;
  localparam int         DPC_LOOP_SEL_BIT  = 3;
  localparam int         DPC_AUTO_INIT_BIT = 4;
  localparam int         DPC_FT_LO_BIT     = 5;
  localparam int         DPC_FT_HI_BIT     = 6;
  localparam logic [7:0] DPC_CFG_RESET     = 8'h04;
  localparam logic [7:0] DPC_CFG_MASK      = 8'h7f;

  // ----------------------------------------------------------------
  // FIFO thresholds in bytes, and transmit offset
  // ----------------------------------------------------------------
  localparam logic [4:0] DPC_THR_BYTES_0   = 5'h02;
  localparam logic [4:0] DPC_THR_BYTES_1   = 5'h04;
  localparam logic [4:0] DPC_THR_BYTES_2   = 5'h08;
  localparam logic [4:0] DPC_THR_BYTES_3   = 5'h0c;
  localparam logic [5:0] DPC_TX_THR_OFFSET = 6'h0d;

  // ----------------------------------------------------------------
  // AXI responses
  // ----------------------------------------------------------------
  localparam logic [1:0] DPC_RESP_OKAY     = 2'h0;
  localparam logic [1:0] DPC_RESP_SLVERR   = 2'h2;
  localparam logic [1:0] DPC_RESP_DECERR   = 2'h3;

  typedef enum logic {DPC_B_IDLE, DPC_B_RUN} dpc_burst_state_t;

endpackage
